// File: rtl/tofc_top.sv
// command interpreter, offset store and offset calibration per tap
`timescale 1ns/1ps
`default_nettype none
module tofc_top
    import tofc_pkg::*;
#(
    parameter int DW = 10,
    parameter int CW = 16,
    parameter int CNT_W = 24,
    parameter int ITER_MAX = 2048
) (
    input wire logic sys_clk, // system clock 200 MHz
    input wire logic rst_b, // async reset, low
    input wire logic cmd_valid, // command offered
    output logic cmd_ready, // command can be taken
    input wire logic [2:0] cmd_op, // command code
    input wire logic [2:0] cmd_tap, // tap selector
    input wire logic [9:0] cmd_value, // command value
    output logic cmd_done, // command finished, pulse
    output logic cmd_err, // command refused, pulse
    input wire logic vid_mode, // 1 calibrated video
    input wire logic data_10b, // 1 ten-bit data mode
    input wire logic [1:0] lines_sel, // sample line code
    input wire logic pix_valid, // raw pixel strobe
    input wire logic [1:0] pix_tap, // raw pixel tap
    input wire logic [DW-1:0] pix_data, // raw pixel
    input wire logic [CW-1:0] pix_prnu, // pixel gain coef
    input wire logic line_end, // end of line pulse
    output logic out_valid, // processed strobe
    output logic [1:0] out_tap, // processed tap
    output logic [DW-1:0] out_data, // processed pixel
    output logic [4*10-1:0] afe_offset, // front end codes
    output logic cal_busy // calibration running
);
    localparam int SUM_W = CNT_W + 10;
    localparam logic [15:0] ITER_LAST = 16'(ITER_MAX - 1);

    function automatic logic tap_hit(input logic [2:0] sel,
                                     input logic [1:0] idx);
        return (sel == 3'h0) || (sel == {1'b0, idx} + 3'h1);
    endfunction

    tofc_state_t state_q;
    logic [9:0] aoff_cal_q [TAP_N];
    logic [9:0] aoff_unc_q [TAP_N];
    logic [8:0] doff_q [TAP_N];
    logic [8:0] bg_q [TAP_N];
    logic [8:0] gain_q [TAP_N];
    logic [SUM_W-1:0] sum_q [TAP_N];
    logic [CNT_W-1:0] cnt_q [TAP_N];
    logic [1:0] dir_q [TAP_N];
    logic [TAP_N-1:0] sel_q, fin_q;
    logic [9:0] tgt_q;
    logic [6:0] lines_q;
    logic [15:0] iter_q;
    logic done_q, err_q;

    // range checks per command; a bad tap or value refuses it
    wire take = cmd_valid && cmd_ready;
    wire tap_ok = cmd_tap <= TAP_MAX;
    wire [9:0] cao_lo = data_10b ? CAO_MIN_10B : CAO_MIN_8B;
    wire [9:0] cao_hi = data_10b ? CAO_MAX_10B : CAO_MAX_8B;
    wire is_dig = (cmd_op == OP_SSB) || (cmd_op == OP_SDO) ||
                  (cmd_op == OP_SSG);
    wire val_ok = (cmd_op == OP_SAO) ? (cmd_value <= AOFF_MAX) :
                  is_dig ? (cmd_value <= DIG_MAX) :
                  (cmd_op == OP_CAO) ?
                  (cmd_value >= cao_lo && cmd_value <= cao_hi) :
                  1'b0;
    wire cmd_ok = tap_ok && val_ok;
    wire ok_take = take && cmd_ok;
    wire [8:0] val9 = cmd_value[8:0];

    // tap mask of an accepted calibration command
    logic [TAP_N-1:0] cmd_mask;
    always_comb begin
        cmd_mask = '0;
        for (int i = 0; i < TAP_N; i++) begin
            cmd_mask[i] = tap_hit(cmd_tap, 2'(i));
        end
    end

    // number of lines in one average, unused code gives the default
    wire [6:0] lines_n = (lines_sel == LN_16) ? LINES_16 :
                         (lines_sel == LN_32) ? LINES_32 :
                         LINES_64;

    // line average against target, done as sum against target times count
    function automatic logic [1:0] avg_cmp(input logic [SUM_W-1:0] sum,
                                           input logic [CNT_W-1:0] cnt,
                                           input logic [9:0] tgt);
        logic [SUM_W-1:0] ref_v;
        ref_v = SUM_W'(cnt) * SUM_W'(tgt);
        if (sum < ref_v) begin
            return DIR_UP;
        end
        if (sum > ref_v) begin
            return DIR_DOWN;
        end
        return DIR_NONE;
    endfunction

    wire all_fin = ((fin_q | ~sel_q) == {TAP_N{1'b1}});
    wire iter_out = iter_q == ITER_LAST;

    // calibration sequencer: discard one line after each trim, then average
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
            lines_q <= '0;
            iter_q <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    iter_q <= '0;
                    if (ok_take && cmd_op == OP_CAO) begin
                        state_q <= ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    lines_q <= '0;
                    if (line_end) begin
                        state_q <= ST_ACCUM;
                    end
                end
                ST_ACCUM: begin
                    if (line_end) begin
                        lines_q <= lines_q + 7'h01;
                        if (lines_q + 7'h01 >= lines_n) begin
                            state_q <= ST_ADJUST;
                        end
                    end
                end
                ST_ADJUST: begin
                    iter_q <= iter_q + 16'h0001;
                    state_q <= (all_fin || iter_out) ? ST_IDLE : ST_SETTLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // target, tap mask and the one-cycle answers
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tgt_q <= '0;
            sel_q <= '0;
            done_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            done_q <= (ok_take && cmd_op != OP_CAO) ||
                      (state_q == ST_ADJUST && all_fin);
            err_q <= (take && !cmd_ok) ||
                     (state_q == ST_ADJUST && !all_fin && iter_out);
            if (ok_take && cmd_op == OP_CAO) begin
                tgt_q <= cmd_value;
                sel_q <= cmd_mask;
            end
        end
    end

    // per-tap stores, line sums and trim steps
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            fin_q <= '0;
            for (int i = 0; i < TAP_N; i++) begin
                aoff_cal_q[i] <= RST_AOFF;
                aoff_unc_q[i] <= RST_AOFF;
                doff_q[i] <= RST_DIG;
                bg_q[i] <= RST_DIG;
                gain_q[i] <= RST_DIG;
                sum_q[i] <= '0;
                cnt_q[i] <= '0;
                dir_q[i] <= DIR_NONE;
            end
        end else begin
            for (int i = 0; i < TAP_N; i++) begin
                if (ok_take && tap_hit(cmd_tap, 2'(i))) begin
                    if (cmd_op == OP_SAO && vid_mode) begin
                        aoff_cal_q[i] <= cmd_value;
                    end
                    if (cmd_op == OP_SAO && !vid_mode) begin
                        aoff_unc_q[i] <= cmd_value;
                    end
                    if (cmd_op == OP_SSB) begin
                        bg_q[i] <= val9;
                    end
                    if (cmd_op == OP_SDO) begin
                        doff_q[i] <= val9;
                    end
                    if (cmd_op == OP_SSG) begin
                        gain_q[i] <= val9;
                    end
                end
                if (ok_take && cmd_op == OP_CAO) begin
                    fin_q[i] <= 1'b0;
                    dir_q[i] <= DIR_NONE;
                end
                if (state_q == ST_SETTLE) begin
                    sum_q[i] <= '0;
                    cnt_q[i] <= '0;
                end
                // raw video only, so the trim sees the front end itself
                if (state_q == ST_ACCUM && pix_valid && pix_tap == 2'(i)) begin
                    sum_q[i] <= sum_q[i] + SUM_W'(pix_data);
                    cnt_q[i] <= cnt_q[i] + CNT_W'(1);
                end
                // a reversal of direction means the target is bracketed
                if (state_q == ST_ADJUST && sel_q[i] && !fin_q[i]) begin
                    case (avg_cmp(sum_q[i], cnt_q[i], tgt_q))
                        DIR_UP: begin
                            if (dir_q[i] == DIR_DOWN ||
                                aoff_unc_q[i] == AOFF_MAX) begin
                                fin_q[i] <= 1'b1;
                            end else begin
                                aoff_unc_q[i] <=
                                    aoff_unc_q[i] + 10'h001;
                                dir_q[i] <= DIR_UP;
                            end
                        end
                        DIR_DOWN: begin
                            if (dir_q[i] == DIR_UP ||
                                aoff_unc_q[i] == 10'h000) begin
                                fin_q[i] <= 1'b1;
                            end else begin
                                aoff_unc_q[i] <=
                                    aoff_unc_q[i] - 10'h001;
                                dir_q[i] <= DIR_DOWN;
                            end
                        end
                        default: begin
                            fin_q[i] <= 1'b1;
                        end
                    endcase
                end
            end
        end
    end

    // front end gets the active mode's code; calibration forces uncalibrated
    for (genvar g = 0; g < TAP_N; g++) begin : g_afe
        assign afe_offset[g*10 +: 10] = (vid_mode && !cal_busy) ?
            aoff_cal_q[g] : aoff_unc_q[g];
    end

    assign cmd_ready = state_q == ST_IDLE;
    assign cal_busy = state_q != ST_IDLE;
    assign cmd_done = done_q;
    assign cmd_err = err_q;

    // settings of the pixel's own tap feed the datapath
    wire [8:0] doff_sel = doff_q[pix_tap];
    wire [8:0] bg_sel = bg_q[pix_tap];
    wire [8:0] gain_sel = gain_q[pix_tap];

    tofc_pix #(
        .DW(DW),
        .CW(CW)
    ) u_pix (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .in_valid(pix_valid),
        .in_tap(pix_tap),
        .in_data(pix_data),
        .in_prnu(pix_prnu),
        .cal_mode(vid_mode),
        .doff(doff_sel),
        .bg(bg_sel),
        .gain(gain_sel),
        .out_valid(out_valid),
        .out_tap(out_tap),
        .out_data(out_data)
    );
endmodule
`default_nettype wire

// File: rtl/tofc_pkg.sv
// shared constants and types for the per-tap offset control block
package tofc_pkg;
    localparam int TAP_N = 4;
    // command codes
    localparam logic [2:0] OP_SAO = 3'h0;
    localparam logic [2:0] OP_SSB = 3'h1;
    localparam logic [2:0] OP_SDO = 3'h2;
    localparam logic [2:0] OP_SSG = 3'h3;
    localparam logic [2:0] OP_CAO = 3'h4;
    // value ranges
    localparam logic [2:0] TAP_MAX = 3'h4;
    localparam logic [9:0] AOFF_MAX = 10'h3ff;
    localparam logic [9:0] DIG_MAX = 10'h1ff;
    localparam logic [9:0] CAO_MIN_8B = 10'h001;
    localparam logic [9:0] CAO_MAX_8B = 10'h064;
    localparam logic [9:0] CAO_MIN_10B = 10'h004;
    localparam logic [9:0] CAO_MAX_10B = 10'h190;
    // sample line selector codes; code 3 falls back to the default
    localparam logic [1:0] LN_16 = 2'h0;
    localparam logic [1:0] LN_32 = 2'h1;
    localparam logic [1:0] LN_64 = 2'h2;
    localparam logic [6:0] LINES_16 = 7'h10;
    localparam logic [6:0] LINES_32 = 7'h20;
    localparam logic [6:0] LINES_64 = 7'h40;
    // reset values of stored settings
    localparam logic [9:0] RST_AOFF = 10'h000;
    localparam logic [8:0] RST_DIG = 9'h000;
    // fixed point positions
    localparam int GAIN_FRAC = 9;
    localparam int PRNU_FRAC = 12;
    // calibration trim direction memory
    localparam logic [1:0] DIR_NONE = 2'h0;
    localparam logic [1:0] DIR_UP = 2'h1;
    localparam logic [1:0] DIR_DOWN = 2'h2;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SETTLE = 2'b01,
        ST_ACCUM = 2'b11,
        ST_ADJUST = 2'b10
    } tofc_state_t;
endpackage

// File: rtl/tofc_pix.sv
// per-pixel digital offset, gain correction, background and gain path
`timescale 1ns/1ps
`default_nettype none
module tofc_pix
    import tofc_pkg::*;
#(
    parameter int DW = 10,
    parameter int CW = 16
) (
    input wire logic sys_clk, // system clock
    input wire logic rst_b, // async reset, low
    input wire logic in_valid, // pixel strobe
    input wire logic [1:0] in_tap, // tap of pixel
    input wire logic [DW-1:0] in_data, // raw pixel
    input wire logic [CW-1:0] in_prnu, // gain coefficient
    input wire logic cal_mode, // calibrated video
    input wire logic [8:0] doff, // digital offset
    input wire logic [8:0] bg, // background value
    input wire logic [8:0] gain, // digital gain code
    output logic out_valid, // pixel strobe out
    output logic [1:0] out_tap, // tap of pixel out
    output logic [DW-1:0] out_data // processed pixel
);
    localparam int PW = DW + CW;

    function automatic logic [DW-1:0] sub_clamp(input logic [DW-1:0] a,
                                                input logic [DW-1:0] b);
        return (a > b) ? a - b : '0;
    endfunction

    function automatic logic [DW-1:0] sat_w(input logic [PW-1:0] v);
        return (|v[PW-1:DW]) ? '1 : v[DW-1:0];
    endfunction

    logic [3:0] vld_q;
    logic [1:0] tap1_q, tap2_q, tap3_q;
    logic [DW-1:0] s1_q, s2_q, s3_q;
    logic [CW-1:0] prnu_q;
    logic cal1_q;
    logic [8:0] bg1_q, bg2_q, gain1_q, gain2_q, gain3_q;

    // stage 1 offset removal only in calibrated mode
    wire [DW-1:0] doff_w = DW'(doff);
    wire [DW-1:0] s1_d = cal_mode ?
        sub_clamp(in_data, doff_w) : in_data;
    // stage 2 per-pixel gain correction, bypassed when uncalibrated
    wire [PW-1:0] p2_w = PW'(s1_q) * PW'(prnu_q);
    wire [DW-1:0] s2_d = cal1_q ? sat_w(p2_w >> PRNU_FRAC) : s1_q;
    // stage 3 background subtraction
    wire [DW-1:0] s3_d = sub_clamp(s2_q, DW'(bg2_q));
    // stage 4 gain of one plus code over 512, saturating at full scale
    wire [PW-1:0] p4_w = PW'(s3_q) * PW'({1'b1, gain3_q});
    wire [DW-1:0] s4_d = sat_w(p4_w >> GAIN_FRAC);

    // four stage pipeline, settings travel with their pixel
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            vld_q <= '0;
            {tap1_q, tap2_q, tap3_q, out_tap} <= '0;
            {s1_q, s2_q, s3_q, out_data} <= '0;
            prnu_q <= '0;
            cal1_q <= 1'b0;
            {bg1_q, bg2_q, gain1_q, gain2_q, gain3_q} <= '0;
        end else begin
            vld_q <= {vld_q[2:0], in_valid};
            tap1_q <= in_tap;
            tap2_q <= tap1_q;
            tap3_q <= tap2_q;
            out_tap <= tap3_q;
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            out_data <= s4_d;
            prnu_q <= in_prnu;
            cal1_q <= cal_mode;
            bg1_q <= bg;
            bg2_q <= bg1_q;
            gain1_q <= gain;
            gain2_q <= gain1_q;
            gain3_q <= gain2_q;
        end
    end

    assign out_valid = vld_q[3];
endmodule
`default_nettype wire

// File: bench/tofc_chk_assertions.sv
// checker for the offset control top module, bound at its ports
`timescale 1ns/1ps
`default_nettype none
module tofc_chk
    import tofc_pkg::*;
(
    input wire logic sys_clk, // clock
    input wire logic rst_b, // reset, low
    input wire logic cmd_valid, // offer
    input wire logic cmd_ready, // free
    input wire logic [2:0] cmd_op, // code
    input wire logic [2:0] cmd_tap, // tap
    input wire logic [9:0] cmd_value, // value
    input wire logic cmd_done, // done
    input wire logic cmd_err, // refused
    input wire logic vid_mode, // mode
    input wire logic data_10b, // width
    input wire logic pix_valid, // pixel in
    input wire logic [1:0] pix_tap, // tap in
    input wire logic out_valid, // pixel out
    input wire logic [1:0] out_tap, // tap out
    input wire logic [39:0] afe_offset, // codes
    input wire logic cal_busy // trimming
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    logic take;
    logic bad_tgt;
    logic [9:0] tlo;
    logic [9:0] thi;
    // taking edge and target window of the current data width
    assign take = cmd_valid && cmd_ready;
    assign tlo = data_10b ? CAO_MIN_10B : CAO_MIN_8B;
    assign thi = data_10b ? CAO_MAX_10B : CAO_MAX_8B;
    assign bad_tgt = (cmd_value < tlo) || (cmd_value > thi);
    // plain commands answer next cycle, exactly one way
    chk_cmd_answer: assert property (
        take && cmd_op != OP_CAO |=> cmd_done != cmd_err)
        else $error("command answer missing or doubled");
    chk_tap_refused: assert property (
        take && cmd_tap > TAP_MAX |=> cmd_err && !cmd_done)
        else $error("bad tap not refused");
    // a command refused for its tap leaves the front end codes alone
    chk_refuse_keeps: assert property (
        take && cmd_tap > TAP_MAX ##1 $stable(vid_mode)
        |-> $stable(afe_offset))
        else $error("refused command changed a code");
    chk_all_taps: assert property (
        take && cmd_op == OP_SAO && cmd_tap == 3'h0 ##1 $stable(vid_mode)
        |-> afe_offset == {4{$past(cmd_value)}})
        else $error("tap zero did not reach every tap");
    chk_pix_latency: assert property (
        pix_valid |-> ##4 out_valid && out_tap == $past(pix_tap, 4))
        else $error("pixel not out after four cycles");
    chk_target_range: assert property (
        take && cmd_op == OP_CAO && cmd_tap <= TAP_MAX && bad_tgt
        |=> cmd_err && !cal_busy)
        else $error("bad target started a calibration");
    // trim moves the code by one step at most per cycle
    chk_trim_step: assert property (
        cal_busy ##1 cal_busy |-> (afe_offset[9:0] -
        $past(afe_offset[9:0])) inside {10'h000, 10'h001, 10'h3ff})
        else $error("trim jumped by more than one");
    // an answer while trimming means a command slipped in
    chk_busy_blocks: assert property (
        cal_busy |-> !cmd_done && !cmd_err)
        else $error("command answered while trimming");
    chk_cal_end: assert property (
        $fell(cal_busy) |-> cmd_done != cmd_err)
        else $error("calibration ended without answer");
    // main scenarios
    cov_cal_done: cover property ($fell(cal_busy) && cmd_done);
    cov_refused: cover property (take && cmd_tap > TAP_MAX);
    cov_pixel: cover property (out_valid);
endmodule
bind tofc_top tofc_chk u_chk (.*);
`default_nettype wire

// File: bench/tofc_host.sv
// host model: offers one command at a time on the command port
`timescale 1ns/1ps
`default_nettype none
module tofc_host (
    input wire logic sys_clk, // clock
    input wire logic cmd_ready, // device free
    input wire logic cmd_done, // completed
    input wire logic cmd_err, // refused
    output logic cmd_valid, // offer
    output logic [2:0] cmd_op, // code
    output logic [2:0] cmd_tap, // tap
    output logic [9:0] cmd_value // value
);
    // idle port at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_op = 3'h0;
        cmd_tap = 3'h0;
        cmd_value = 10'h155;
    end
    // hold the offer until a taking edge, then wait for the answer
    task automatic send(input logic [2:0] op, input logic [2:0] tap,
                        input logic [9:0] v, input int wmax,
                        output logic [1:0] res);
        int n;
        n = 0;
        @(negedge sys_clk);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_tap = tap;
        cmd_value = v;
        // ready is settled at the falling edge and stands to the next rise
        while (cmd_ready !== 1'b1 && n < wmax) begin
            n++;
            @(negedge sys_clk);
        end
        // the taking edge passes before the offer drops
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        cmd_value = ~v; // stale value would hide a late sample
        res = {cmd_err, cmd_done};
        while (res == 2'h0 && n < wmax) begin
            n++;
            @(negedge sys_clk);
            res = {cmd_err, cmd_done};
        end
    endtask
endmodule
`default_nettype wire

// File: bench/tofc_top_tb.sv
// self-checking bench for the per-tap offset control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin \
    if ((got) !== (exp)) begin \
        $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); \
        num_errors++; \
    end \
    n_checks++; \
end
module tofc_top_tb import tofc_pkg::*;;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic vid_mode = 1'b0;
    logic data_10b = 1'b0;
    logic [1:0] lines_sel = 2'h0;
    logic pix_valid = 1'b0;
    logic [1:0] pix_tap = 2'h0;
    logic [9:0] pix_data = 10'h000;
    logic [15:0] pix_prnu = 16'h1000;
    logic line_end = 1'b0;
    logic cmd_valid, cmd_ready, cmd_done, cmd_err, out_valid, cal_busy;
    logic [2:0] cmd_op, cmd_tap;
    logic [9:0] cmd_value, out_data;
    logic [1:0] out_tap, res;
    logic [39:0] afe_offset;
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    tofc_host u_host (.*);
    // short iteration limit keeps a runaway trim brief
    tofc_top #(.ITER_MAX(8)) dut (.*);
    always #2.5 sys_clk = ~sys_clk;
    task automatic give_verdict;
        if (num_errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // hang guard, far above the expected run length
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            give_verdict();
        end
    end
    task automatic cmd(input logic [2:0] op, input logic [2:0] tap,
                       input logic [9:0] v, input logic [1:0] exp);
        u_host.send(op, tap, v, 20, res);
        `CHK("cmd answer", exp, res)
    endtask
    task automatic setmode(input logic m);
        @(negedge sys_clk);
        vid_mode = m;
        #1;
    endtask
    // one pixel in, its result four cycles later
    task automatic pix(input logic [1:0] t, input logic [9:0] d,
                       input logic [9:0] exp);
        @(negedge sys_clk);
        pix_valid = 1'b1;
        pix_tap = t;
        pix_data = d;
        @(negedge sys_clk);
        pix_valid = 1'b0;
        pix_data = ~d;
        repeat (3) @(negedge sys_clk);
        `CHK("out_valid", 1'b1, out_valid)
        `CHK("out_tap", t, out_tap)
        `CHK("out_data", exp, out_data)
    endtask
    // camera lines whose level follows the trimmed code of tap 1
    task automatic feed_lines;
        int k;
        k = 0;
        repeat (3) @(negedge sys_clk);
        while (cal_busy === 1'b1 && k < 400) begin
            pix_valid = 1'b1;
            pix_tap = 2'h0;
            pix_data = afe_offset[9:0];
            @(negedge sys_clk);
            pix_valid = 1'b0;
            pix_data = ~pix_data;
            line_end = 1'b1;
            @(negedge sys_clk);
            line_end = 1'b0;
            k++;
        end
    endtask
    initial begin
        repeat (5) @(negedge sys_clk);
        rst_b = 1'b1;
        `CHK("ready", 1'b1, cmd_ready)
        `CHK("afe", 40'h0, afe_offset)
        // analog offset banks, all taps and one tap
        cmd(OP_SAO, 3'h0, 10'h0c8, 2'h1);
        `CHK("afe", {4{10'h0c8}}, afe_offset)
        setmode(1'b1);
        `CHK("afe", 40'h0, afe_offset)
        cmd(OP_SAO, 3'h4, 10'h3ff, 2'h1);
        `CHK("afe", {10'h3ff, 30'h0}, afe_offset)
        cmd(OP_SAO, 3'h5, 10'h007, 2'h2);
        cmd(3'h7, 3'h1, 10'h007, 2'h2);
        `CHK("afe", {10'h3ff, 30'h0}, afe_offset)
        setmode(1'b0);
        `CHK("afe", {4{10'h0c8}}, afe_offset)
        // background, clamp and gain in uncalibrated video
        cmd(OP_SSB, 3'h1, 10'h014, 2'h1);
        cmd(OP_SSB, 3'h2, 10'h200, 2'h2);
        pix(2'h0, 10'h064, 10'h050);
        pix(2'h0, 10'h00a, 10'h000);
        pix(2'h1, 10'h064, 10'h064);
        cmd(OP_SSG, 3'h1, 10'h1ff, 2'h1);
        pix(2'h0, 10'h064, 10'h09f);
        pix(2'h0, 10'h3ff, 10'h3ff);
        // digital offset ahead of the gain correction
        cmd(OP_SDO, 3'h2, 10'h032, 2'h1);
        setmode(1'b1);
        pix_prnu = 16'h2000;
        pix(2'h1, 10'h064, 10'h064);
        pix(2'h1, 10'h014, 10'h000);
        setmode(1'b0);
        pix(2'h1, 10'h064, 10'h064);
        pix_prnu = 16'h1000;
        // calibration targets and a trim from 97 up to 100
        cmd(OP_SAO, 3'h1, 10'h061, 2'h1);
        cmd(OP_CAO, 3'h1, 10'h000, 2'h2);
        cmd(OP_CAO, 3'h1, 10'h065, 2'h2);
        data_10b = 1'b1;
        cmd(OP_CAO, 3'h1, 10'h003, 2'h2);
        cmd(OP_CAO, 3'h1, 10'h191, 2'h2);
        data_10b = 1'b0;
        // a longer average of 32 lines, up from 16, for the trim run
        lines_sel = 2'h1;
        setmode(1'b1);
        fork
            u_host.send(OP_CAO, 3'h1, 10'h064, 5000, res);
            feed_lines();
        join
        `CHK("cal answer", 2'h1, res)
        `CHK("busy", 1'b0, cal_busy)
        `CHK("afe", {10'h3ff, 30'h0}, afe_offset)
        setmode(1'b0);
        `CHK("afe", {{3{10'h0c8}}, 10'h064}, afe_offset)
        give_verdict();
    end
endmodule
`default_nettype wire
